// ===== hw/conditional_branch_unit.sv
// conditional relative branch evaluation between decode and program counter
//
// Contract
// RULE1: not-equal branch jumps when null flag clear
// RULE2: carry-set branch jumps when carry is one
// RULE3: carry-clear branch jumps when carry is zero
// RULE4: same-or-higher branch equals carry-clear branch
// RULE5: lower branch equals carry-set branch
// RULE6: negative branch jumps when negative flag set
// RULE7: positive branch jumps when negative flag clear
// RULE8: signed at-least jumps when negative xor overflow zero
// RULE9: signed below jumps when negative xor overflow one
// RULE10: nibble-carry-set branch jumps when nibble carry one
// RULE11: nibble-carry-clear branch jumps when nibble carry zero
// RULE12: user-flag-set branch jumps when user flag one
// RULE13: user-flag-clear branch jumps when user flag zero
// RULE14: taken target is counter plus offset plus one
// RULE15: no status flag ever changes
// RULE16: branch finishes in one or two cycles
// RULE17: offset signed; extra cycle only when taken
`timescale 1ns/1ns
`default_nettype none

module conditional_branch_unit
  import branch_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // request from decode
  input wire branch_req_s req,
  output logic ready,
  // answer to program counter stage
  output var branch_ans_s ans,
  // status flags handed back untouched
  output var status_flags_s flags_out,
  output logic flags_write
);

  // whole state of the unit
  typedef struct packed {
    branch_phase_e phase;
    branch_ans_s ans;
    status_flags_s flags;
  } unit_state_s;

  localparam unit_state_s STATE_RESET = '{
    phase: ph_idle,
    ans: '{done: 1'b0, taken: 1'b0, illegal: 1'b0,
           program_counter: PC_RESET},
    flags: FLAGS_RESET
  };

  // registered state and its next value
  unit_state_s st;
  unit_state_s next_st;
  // per-request decode, meaningful only in the issue cycle
  logic issue;
  logic cond;
  logic known;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] fall_through;

  // a new branch is accepted only while no taken branch is pending
  assign ready = (st.phase == ph_idle);
  assign issue = req.valid && ready;

  // condition select; codes above the last kind are refused as illegal
  always_comb begin
    cond = 1'b0;
    known = 1'b1;
    unique case (req.kind)
      branch_if_nonzero: cond = (req.flags.null_result == 1'b0); // [RULE1]
      branch_carry_set: cond = (req.flags.carry == 1'b1); // [RULE2]
      branch_carry_clear: cond = (req.flags.carry == 1'b0); // [RULE3]
      // same test as carry-clear, kept as its own kind for decode
      branch_unsigned_at_least: cond = (req.flags.carry == 1'b0); // [RULE4]
      branch_unsigned_below: cond = (req.flags.carry == 1'b1); // [RULE5]
      branch_negative: cond = (req.flags.negative == 1'b1); // [RULE6]
      branch_positive: cond = (req.flags.negative == 1'b0); // [RULE7]
      branch_signed_at_least: begin
        cond = ((req.flags.negative ^ req.flags.overflow) == 1'b0); // [RULE8]
      end
      branch_signed_below: begin
        cond = ((req.flags.negative ^ req.flags.overflow) == 1'b1); // [RULE9]
      end
      branch_nibble_carry_set: begin
        cond = (req.flags.nibble_carry == 1'b1); // [RULE10]
      end
      branch_nibble_carry_clear: begin
        cond = (req.flags.nibble_carry == 1'b0); // [RULE11]
      end
      branch_user_flag_set: cond = (req.flags.user_flag == 1'b1); // [RULE12]
      branch_user_flag_clear: cond = (req.flags.user_flag == 1'b0); // [RULE13]
      default: known = 1'b0;
    endcase
  end

  // sign-extend the displacement so backward jumps wrap correctly
  // the sum wraps at the counter width, as the fetch path expects
  assign target = req.program_counter
                  + {{(PC_W-OFF_W){req.offset[OFF_W-1]}}, req.offset}
                  + PC_STEP; // [RULE14] [RULE17]
  assign fall_through = req.program_counter + PC_STEP;

  // sequencer: fall-through answers next cycle, taken one cycle later
  always_comb begin
    next_st = st;
    next_st.ans.done = 1'b0;
    unique case (st.phase)
      ph_idle: begin
        if (issue) begin
          next_st.flags = req.flags; // [RULE15]
          next_st.ans.illegal = !known;
          if (known && cond) begin
            // target held until the second cycle ends
            next_st.phase = ph_taken; // [RULE16] [RULE17]
            next_st.ans.taken = 1'b1;
            next_st.ans.program_counter = target;
          end else begin
            next_st.ans.done = 1'b1; // [RULE16]
            next_st.ans.taken = 1'b0;
            next_st.ans.program_counter = fall_through;
          end
        end
      end
      ph_taken: begin
        next_st.phase = ph_idle;
        next_st.ans.done = 1'b1; // [RULE16]
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= STATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign ans = st.ans;
  assign flags_out = st.flags;
  // the unit never writes status, whatever the outcome
  assign flags_write = 1'b0; // [RULE15]

  // checks of each branch test against the flags seen at issue
  a_nonzero_test: assert property ( // [RULE1]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_if_nonzero)
    |=> ((st.phase == ph_taken) == !$past(req.flags.null_result)))
    else $error("nonzero branch decision wrong");

  // carry tests; the unsigned pair reuses them
  a_carry_set: assert property ( // [RULE2]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_carry_set)
    |=> ((st.phase == ph_taken) == $past(req.flags.carry)))
    else $error("carry set branch decision wrong");

  a_carry_clear: assert property ( // [RULE3]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_carry_clear)
    |=> ((st.phase == ph_taken) == !$past(req.flags.carry)))
    else $error("carry clear branch decision wrong");

  a_unsigned_at_least: assert property ( // [RULE4]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_unsigned_at_least && req.flags.carry)
    |=> (st.ans.done && !st.ans.taken))
    else $error("same or higher branch taken on carry");

  a_unsigned_below: assert property ( // [RULE5]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_unsigned_below)
    |=> ((st.phase == ph_taken) == $past(req.flags.carry)))
    else $error("lower branch decision wrong");

  // tests on the sign of the last result
  a_negative_test: assert property ( // [RULE6]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_negative)
    |=> ((st.phase == ph_taken) == $past(req.flags.negative)))
    else $error("negative branch decision wrong");

  a_positive_test: assert property ( // [RULE7]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_positive && !req.flags.negative)
    |=> (st.phase == ph_taken) ##1 (st.ans.done && st.ans.taken))
    else $error("positive branch not taken");

  // signed compares look at negative xor overflow
  a_signed_at_least: assert property ( // [RULE8]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_signed_at_least)
    |=> ((st.phase == ph_taken)
         == !($past(req.flags.negative) ^ $past(req.flags.overflow))))
    else $error("signed at least branch decision wrong");

  a_signed_below: assert property ( // [RULE9]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_signed_below)
    |=> ((st.phase == ph_taken)
         == ($past(req.flags.negative) ^ $past(req.flags.overflow))))
    else $error("signed below branch decision wrong");

  // nibble carry tests
  a_nibble_set: assert property ( // [RULE10]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_nibble_carry_set)
    |=> ((st.phase == ph_taken) == $past(req.flags.nibble_carry)))
    else $error("nibble carry set branch decision wrong");

  a_nibble_clear: assert property ( // [RULE11]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_nibble_carry_clear)
    |=> ((st.phase == ph_taken) == !$past(req.flags.nibble_carry)))
    else $error("nibble carry clear branch decision wrong");

  // spare user flag tests
  a_user_set: assert property ( // [RULE12]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_user_flag_set)
    |=> ((st.phase == ph_taken) == $past(req.flags.user_flag)))
    else $error("user flag set branch decision wrong");

  a_user_clear: assert property ( // [RULE13]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind == branch_user_flag_clear)
    |=> ((st.phase == ph_taken) == !$past(req.flags.user_flag)))
    else $error("user flag clear branch decision wrong");

  // target arithmetic, including backward jumps
  a_target_sum: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && known && cond)
    |=> ##1 (st.ans.done && st.ans.program_counter
             == $past(req.program_counter, 2)
                + {{(PC_W-OFF_W){$past(req.offset[OFF_W-1], 2)}},
                   $past(req.offset, 2)}
                + PC_STEP))
    else $error("taken target not counter plus offset plus one");

  // a fall-through leaves the counter one past the branch
  a_fall_through: assert property ( // [RULE14]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && !(known && cond))
    |=> (st.ans.program_counter == $past(req.program_counter) + PC_STEP))
    else $error("fall through counter not advanced by one");

  // flags pass through unchanged and are never written;
  // only a back-to-back issue may replace the copy
  a_flags_kept: assert property ( // [RULE15]
    @(posedge ref_clk) disable iff (!rst_b)
    issue |=> (flags_out == $past(req.flags)) && !flags_write
              ##1 ($past(issue) || flags_out == $past(flags_out)))
    else $error("status flags changed by branch");

  // completion timing: one cycle when falling through, two when taken
  a_fall_timing: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && !(known && cond)) |=> st.ans.done && ready)
    else $error("fall through not finished in one cycle");

  a_taken_timing: assert property ( // [RULE16] [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && known && cond)
    |=> (!st.ans.done && !ready) ##1 (st.ans.done && st.ans.taken && ready))
    else $error("taken branch not finished in two cycles");

  // done is a pulse unless another branch follows at once
  a_done_single: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    st.ans.done |=> !st.ans.done || $past(issue))
    else $error("done held without a new branch");

  // a request while busy must not start a new branch
  a_refused_busy: assert property ( // [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    (st.phase == ph_taken && req.valid)
    |=> (st.ans.done && ready && $stable(st.ans.program_counter)))
    else $error("request accepted while a taken branch was pending");

  // codes past the last kind are answered at once and marked
  a_illegal_code: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind > branch_user_flag_clear)
    |=> (st.ans.done && st.ans.illegal && !st.ans.taken))
    else $error("unknown kind not marked illegal");

  // known codes never carry the illegal mark
  a_known_code: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && req.kind <= branch_user_flag_clear)
    |=> !st.ans.illegal)
    else $error("known kind marked illegal");

  // answer and flag copy stand until the next issue
  a_answer_held: assert property ( // [RULE15] [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    !issue |=> $stable(st.ans.program_counter) && $stable(st.ans.taken)
               && $stable(st.ans.illegal) && $stable(flags_out))
    else $error("answer changed without a new branch");

  // busy lasts exactly one cycle and ends with the answer
  a_busy_once: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    !ready |=> (ready && st.ans.done))
    else $error("busy phase not one cycle long");

  // an answer is only ever given from the idle phase
  a_done_ready: assert property ( // [RULE16]
    @(posedge ref_clk) disable iff (!rst_b)
    st.ans.done |-> ready)
    else $error("answer given while still busy");

  // taken target is already shown in the busy cycle
  a_target_early: assert property ( // [RULE14] [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && known && cond)
    |=> (st.ans.taken && st.ans.program_counter
         == $past(req.program_counter)
            + {{(PC_W-OFF_W){$past(req.offset[OFF_W-1])}},
               $past(req.offset)}
            + PC_STEP))
    else $error("taken target not shown in busy cycle");

  // a fall-through never spends the busy cycle
  a_fall_no_busy: assert property ( // [RULE17]
    @(posedge ref_clk) disable iff (!rst_b)
    (issue && !(known && cond)) |=> (st.phase == ph_idle && !st.ans.taken))
    else $error("fall through spent an extra cycle");

  // one edge after reset is seen the unit is idle and writes nothing
  a_reset_quiet: assert property ( // [RULE15]
    @(posedge ref_clk)
    !rst_b |=> (ready && !st.ans.done && !flags_write
                && flags_out == FLAGS_RESET))
    else $error("unit not quiet after reset");

endmodule : conditional_branch_unit

`default_nettype wire

// ===== hw/branch_pkg.sv
// shared types and constants for the conditional branch unit
package branch_pkg;

  // program counter addresses words of an 8K-word program store
  localparam int PC_W = 13;
  // branch displacement is a signed 7-bit field
  localparam int OFF_W = 7;

  // constant added on top of the displacement
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  // program counter value after reset
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;

  // cycles from issue to answer
  localparam int FALL_CYCLES = 1;
  localparam int TAKEN_CYCLES = 2;

  // branch kinds decoded upstream
  typedef enum logic [3:0] {
    branch_if_nonzero = 4'h0,
    branch_carry_set = 4'h1,
    branch_carry_clear = 4'h2,
    branch_unsigned_at_least = 4'h3,
    branch_unsigned_below = 4'h4,
    branch_negative = 4'h5,
    branch_positive = 4'h6,
    branch_signed_at_least = 4'h7,
    branch_signed_below = 4'h8,
    branch_nibble_carry_set = 4'h9,
    branch_nibble_carry_clear = 4'hA,
    branch_user_flag_set = 4'hB,
    branch_user_flag_clear = 4'hC
  } branch_kind_e;

  // status flags; all but sign_flag are seen by the branch tests
  typedef struct packed {
    logic user_flag;
    logic nibble_carry;
    logic sign_flag;
    logic overflow;
    logic negative;
    logic null_result;
    logic carry;
  } status_flags_s;

  // status flags after reset
  localparam status_flags_s FLAGS_RESET = 7'h00;

  // one branch request from decode
  typedef struct packed {
    logic valid;
    logic [3:0] kind;
    logic [OFF_W-1:0] offset;
    logic [PC_W-1:0] program_counter;
    status_flags_s flags;
  } branch_req_s;

  // answer to the program counter stage
  typedef struct packed {
    logic done;
    logic taken;
    logic illegal;
    logic [PC_W-1:0] program_counter;
  } branch_ans_s;

  // sequencer phase
  typedef enum logic [1:0] {
    ph_idle = 2'b00,
    ph_taken = 2'b01
  } branch_phase_e;

endpackage : branch_pkg

// ===== verif/tb_top.sv
// self-checking bench for the conditional branch unit
`timescale 1ns/1ns
`default_nettype none

module tb_top
  import branch_pkg::*;
;
  logic ref_clk;
  logic rst_b;
  branch_req_s req;
  logic ready;
  branch_ans_s ans;
  status_flags_s flags_out;
  logic flags_write;
  int error_cnt;
  int samples_checked;

  conditional_branch_unit DUT (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .req(req),
    .ready(ready),
    .ans(ans),
    .flags_out(flags_out),
    .flags_write(flags_write)
  );

  // 20 MHz core clock
  always #25 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t ns: seen 0x%0h expected 0x%0h",
               $time, seen, exp);
    end
  endtask : check

  // expected branch decision, worked out independently of the design
  function automatic logic cond(input logic [3:0] k, input status_flags_s f);
    case (k)
      4'h0: cond = !f.null_result;
      4'h1, 4'h4: cond = f.carry;
      4'h2, 4'h3: cond = !f.carry;
      4'h5: cond = f.negative;
      4'h6: cond = !f.negative;
      4'h7: cond = !(f.negative ^ f.overflow);
      4'h8: cond = f.negative ^ f.overflow;
      4'h9: cond = f.nibble_carry;
      4'hA: cond = !f.nibble_carry;
      4'hB: cond = f.user_flag;
      4'hC: cond = !f.user_flag;
      default: cond = 1'b0;
    endcase
  endfunction : cond

  // leaves valid high after a fall-through so the next issue is back to back
  task automatic issue(input logic [3:0] k, input status_flags_s f,
                       input logic [OFF_W-1:0] off, input logic [PC_W-1:0] pc,
                       input logic hold, output int lat);
    check(ready, 1'b1);
    req = '{valid: 1'b1, kind: k, offset: off, program_counter: pc, flags: f};
    @(posedge ref_clk);
    #1;
    lat = 1;
    while (ans.done !== 1'b1 && lat < 5) begin
      check(ready, 1'b0);
      req.valid = hold;
      @(posedge ref_clk);
      #1;
      lat++;
    end
    if (ans.done !== 1'b1) begin
      check(ans.done, 1'b1);
      complete_run();
    end
  endtask : issue

  task automatic idle();
    req.valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic run(input logic [3:0] k, input status_flags_s f,
                     input logic [OFF_W-1:0] off, input logic [PC_W-1:0] pc);
    logic t;
    logic [PC_W-1:0] tgt;
    int lat;
    t = cond(k, f);
    tgt = pc + PC_STEP;
    if (t) begin
      tgt = tgt + {{(PC_W - OFF_W){off[OFF_W-1]}}, off};
    end
    issue(k, f, off, pc, 1'b0, lat);
    check(16'(lat), t ? 16'(TAKEN_CYCLES) : 16'(FALL_CYCLES));
    check(ans.taken, t);
    check(ans.program_counter, tgt);
    check(ans.illegal, k > 4'hC);
    check(flags_out, f);
    check(flags_write, 1'b0);
  endtask : run

  // flag pattern and its complement, so a wrong flag choice shows
  task automatic both(input logic [3:0] k, input status_flags_s m);
    run(k, m, 7'h05, 13'h0100);
    run(k, ~m, 7'h05, 13'h0100);
  endtask : both

  task automatic scen_conditions();
    both(branch_if_nonzero, 7'h02);
    both(branch_carry_set, 7'h01);
    both(branch_carry_clear, 7'h01);
    both(branch_unsigned_at_least, 7'h01);
    both(branch_unsigned_below, 7'h01);
    both(branch_negative, 7'h04);
    both(branch_positive, 7'h04);
    both(branch_signed_at_least, 7'h04);
    both(branch_signed_at_least, 7'h0C);
    both(branch_signed_below, 7'h04);
    both(branch_signed_below, 7'h0C);
    both(branch_nibble_carry_set, 7'h20);
    both(branch_nibble_carry_clear, 7'h20);
    both(branch_user_flag_set, 7'h40);
    both(branch_user_flag_clear, 7'h40);
    idle();
  endtask : scen_conditions

  // backward, wrapping and minus-one displacements
  task automatic scen_offsets();
    run(branch_carry_set, 7'h01, 7'h40, 13'h0010);
    run(branch_carry_set, 7'h01, 7'h3F, 13'h1FFF);
    run(branch_carry_set, 7'h01, 7'h7F, 13'h0800);
    idle();
  endtask : scen_offsets

  // valid held through the busy cycle must be ignored
  task automatic scen_refused();
    int lat;
    issue(branch_carry_set, 7'h01, 7'h10, 13'h0200, 1'b1, lat);
    check(16'(lat), 16'(TAKEN_CYCLES));
    idle();
    check(ans.done, 1'b0);
    idle();
    check(ans.done, 1'b0);
    check(ans.program_counter, 13'h0211);
  endtask : scen_refused

  // unknown kind codes fall through
  task automatic scen_illegal();
    for (int k = 13; k < 16; k++) begin
      run(4'(k), 7'h7F, 7'h22, 13'h0300);
      run(4'(k), 7'h00, 7'h22, 13'h0300);
    end
    idle();
  endtask : scen_illegal

  // reset in the middle of a taken branch drops the pending answer
  task automatic scen_reset();
    req = '{valid: 1'b1, kind: branch_carry_set, offset: 7'h04,
            program_counter: 13'h0400, flags: 7'h01};
    @(posedge ref_clk);
    #1;
    check(ready, 1'b0);
    rst_b = 1'b0;
    req.valid = 1'b0;
    #1;
    check(ready, 1'b1);
    check(ans, 16'h0000);
    @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    idle();
    check(ans.done, 1'b0);
    run(branch_carry_clear, 7'h00, 7'h02, 13'h0010);
  endtask : scen_reset

  // reset, then the scenarios in turn
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    req = '0;
    error_cnt = 0;
    samples_checked = 0;
    repeat (16) @(posedge ref_clk);
    #1;
    check(ready, 1'b1);
    check(ans, 16'h0000);
    check(flags_write, 1'b0);
    rst_b = 1'b1;
    idle();
    scen_conditions();
    scen_offsets();
    scen_refused();
    scen_illegal();
    scen_reset();
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
